/* hw/sadc_pkg.sv */
// shared constants, types and decode functions of the converter control sequencer
package sadc_pkg;

	// ==========================================================
	// register bus geometry and map
	localparam int ADDR_W = 3; // byte index of each register
	localparam int DATA_W = 8; // registers are bytes
	localparam logic [2:0] OFS_CTRL0 = 3'h0; // converter_control_zero
	localparam logic [2:0] OFS_CFG1 = 3'h1; // converter_port_reference_config
	localparam logic [2:0] OFS_CFG2 = 3'h2; // converter_timing_format_config
	localparam logic [2:0] OFS_RES_LO = 3'h3; // result_low_byte
	localparam logic [2:0] OFS_RES_HI = 3'h4; // result_high_byte
	localparam logic [2:0] OFS_FLAG = 3'h5; // conversion_done_flag, write one to clear

	// ==========================================================
	// field positions
	localparam int EN_BIT = 0; // converter_enable
	localparam int GO_BIT = 1; // start / conversion status
	localparam int CH_LSB = 2; // channel_select 5:2
	localparam int PCFG_LSB = 0; // pin_analog_config 3:0
	localparam int PREF_BIT = 4; // pos_reference_select
	localparam int NREF_BIT = 5; // neg_reference_select
	localparam int CS_LSB = 0; // conversion_clock_select 2:0
	localparam int ACQ_LSB = 3; // acquisition_period_select 5:3
	localparam int JUST_BIT = 7; // result_justify
	localparam int FLAG_BIT = 0; // conversion_done_flag

	// ==========================================================
	// values after reset and fixed counts
	localparam logic [3:0] CH_RST = 4'h0;
	localparam logic [2:0] FIELD3_RST = 3'h0;
	localparam logic [3:0] PCFG_RST_ANALOG = 4'h0; // option set: all inputs analog
	localparam logic [3:0] PCFG_RST_MIXED = 4'h7; // option clear
	localparam logic [3:0] PCFG_ANALOG_MAX = 4'h2; // codes up to this keep all analog
	localparam logic [4:0] NUM_CH = 5'h0D; // thirteen analog inputs
	localparam logic [3:0] LAST_CH = 4'hC;
	localparam logic [3:0] CONV_TAD = 4'hB; // periods per 10-bit conversion
	localparam logic [3:0] CONV_LAST = CONV_TAD - 4'h1;

	// ==========================================================
	// timing: one instruction cycle is four oscillator periods
	localparam int CLK_PERIOD_PS = 5000;
	localparam int INSTR_CYCLE_PS = 20000;
	localparam int INSTR_CYCLES = (INSTR_CYCLE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

	// sequencer states, gray along idle-delay-acquire-convert
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_DELAY = 2'h1,
		ST_ACQ = 2'h3,
		ST_CONV = 2'h2
	} sadc_state_e;

	// acquisition length in conversion clock periods
	function automatic logic [4:0] acq_tads(input logic [2:0] code);
		case (code)
			3'h7: acq_tads = 5'h14;
			3'h6: acq_tads = 5'h10;
			3'h5: acq_tads = 5'h0C;
			3'h4: acq_tads = 5'h08;
			3'h3: acq_tads = 5'h06;
			3'h2: acq_tads = 5'h04;
			3'h1: acq_tads = 5'h02;
			default: acq_tads = 5'h00;
		endcase
	endfunction

	// oscillator periods per conversion clock period
	function automatic logic [6:0] clk_div(input logic [2:0] code);
		case (code)
			3'h0: clk_div = 7'h02;
			3'h1: clk_div = 7'h08;
			3'h2: clk_div = 7'h20;
			3'h4: clk_div = 7'h04;
			3'h5: clk_div = 7'h10;
			3'h6: clk_div = 7'h40;
			default: clk_div = 7'h02;
		endcase
	endfunction

	// codes x11 pick the internal rc clock
	function automatic logic is_rc(input logic [2:0] code);
		is_rc = (code[1:0] == 2'h3);
	endfunction

endpackage

/* hw/sadc_eng_if.sv */
// bundle between the sequencer, its clock divider and the approximation engine
`timescale 1ns/1ps
`default_nettype none
interface sadc_eng_if;
	logic run; // conversion clock running
	logic [2:0] clk_sel; // conversion_clock_select
	logic rc_edge; // synchronised rc oscillator edge
	logic conversion_clock_period; // one-cycle pulse per conversion clock period
	logic start; // begin an approximation
	logic abort; // drop an approximation
	logic comp; // synchronised comparator
	logic done; // approximation finished, one cycle
	logic [9:0] result; // finished code
	logic [9:0] trial; // code under test on the dac
	modport ctl(output run, clk_sel, rc_edge, start, abort, comp, input conversion_clock_period, done, result, trial);
	modport tk(input run, clk_sel, rc_edge, output conversion_clock_period);
	modport sar(input conversion_clock_period, start, abort, comp, output done, result, trial);
endinterface
`default_nettype wire

/* hw/sadc_tick.sv */
// conversion clock generator: oscillator divider or rc edges
`timescale 1ns/1ps
`default_nettype none
module sadc_tick (
	input wire logic core_clk,
	input wire logic rst_n,
	sadc_eng_if.tk eng
);
	typedef struct packed {
		logic [6:0] cnt; // oscillator periods into this tad
		logic conversion_clock_period; // registered tick
	} sadc_tick_s;
	sadc_tick_s st;
	sadc_tick_s next_st;

	// ==========================================================
	// divider; restarts whenever the sequencer stops it
	always_comb begin
		next_st = st;
		next_st.conversion_clock_period = 1'b0;
		if (!eng.run) begin
			next_st.cnt = 7'h00;
		end else if (sadc_pkg::is_rc(eng.clk_sel)) begin
			next_st.conversion_clock_period = eng.rc_edge;
		end else if (st.cnt == sadc_pkg::clk_div(eng.clk_sel) - 7'h01) begin
			next_st.cnt = 7'h00;
			next_st.conversion_clock_period = 1'b1;
		end else begin
			next_st.cnt = st.cnt + 7'h01;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign eng.conversion_clock_period = st.conversion_clock_period;
endmodule
`default_nettype wire

/* hw/sadc_sar.sv */
// successive approximation engine, one bit trial per conversion clock period
`timescale 1ns/1ps
`default_nettype none
module sadc_sar (
	input wire logic core_clk,
	input wire logic rst_n,
	sadc_eng_if.sar eng
);
	typedef struct packed {
		logic active; // approximation running
		logic [3:0] step; // tad index within the conversion
		logic [9:0] code; // code under test
		logic [9:0] result; // last finished code
		logic done; // finish pulse
	} sadc_sar_s;
	sadc_sar_s st;
	sadc_sar_s next_st;

	// ==========================================================
	// first tad holds the sample, the next ten try bits 9 down to 0
	always_comb begin
		logic [9:0] c;
		logic [3:0] b;
		c = st.code;
		b = 4'h0;
		next_st = st;
		next_st.done = 1'b0;
		if (eng.abort) begin
			next_st.active = 1'b0;
			next_st.step = 4'h0;
		end else if (eng.start) begin
			next_st.active = 1'b1;
			next_st.step = 4'h0;
			next_st.code = 10'h000;
		end else if (st.active && eng.conversion_clock_period) begin
			if (st.step == 4'h0) begin
				c[9] = 1'b1;
			end else begin
				b = 4'hA - st.step;
				// comparator low means input below the trial: drop the bit
				if (!eng.comp) begin
					c[b] = 1'b0;
				end
				if (b != 4'h0) begin
					c[b - 4'h1] = 1'b1;
				end
			end
			next_st.code = c;
			next_st.step = st.step + 4'h1;
			if (st.step == sadc_pkg::CONV_LAST) begin
				next_st.active = 1'b0;
				next_st.done = 1'b1;
				next_st.result = c;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign eng.done = st.done;
	assign eng.result = st.result;
	assign eng.trial = st.code;
endmodule
`default_nettype wire

/* hw/sadc_top.sv */
// converter control sequencer: registers, start sequencing, pin and reference steering
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - channel field 5:2, codes above 12 unimplemented
// - status bit 1 high while converting
// - bit 0 enables, clearing disables converter
// - bit 5 picks negative reference source
// - bit 4 picks positive reference source
// - higher pin codes turn inputs digital downward
// - reset loads pin field from option strap
// - bit 7 chooses right or left justify
// - acquisition code gives 0 to 20 periods
// - clock code picks divider or rc clock
// - rc clock adds one instruction cycle delay
// - reset restores control registers, aborts any conversion
// - completion loads result, clears status, flags
// - result bytes untouched by reset
// - programmed acquisition runs before conversion
// - ten-bit result by successive approximation
// - unimplemented control bits read as zero
// - conversion takes eleven clock periods
// - acquisition code zero converts at once
// - sampling resumes after each conversion
module sadc_top (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [2:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic port_analog_default_option,
	input wire logic comp_in,
	input wire logic rc_osc_tick,
	output logic [3:0] channel_select,
	output logic channel_valid,
	output logic [12:0] pin_analog,
	output logic neg_reference_select,
	output logic pos_reference_select,
	output logic sample_en,
	output logic [9:0] dac_code,
	output logic conversion_done_flag
);
	// ==========================================================
	// state
	typedef struct packed {
		sadc_pkg::sadc_state_e state; // sequencer
		logic en; // converter_enable
		logic [3:0] chan; // channel_select
		logic nref; // neg_reference_select
		logic pref; // pos_reference_select
		logic [3:0] pcfg; // pin_analog_config
		logic justify; // result_justify
		logic [2:0] acq; // acquisition_period_select
		logic [2:0] cs; // conversion_clock_select
		logic [7:0] res_hi; // result_high_byte, never reset
		logic [7:0] res_lo; // result_low_byte, never reset
		logic flag; // conversion_done_flag
		logic [4:0] cnt; // delay cycles or acquisition periods left
		logic start; // kick to the engine
		logic abort; // stop to the engine
		logic [7:0] rdata; // read data, valid one cycle
		logic [12:0] pin_analog; // decoded pin map
		logic comp_s1; // comparator synchroniser
		logic comp_s2;
		logic rc_s1; // rc oscillator synchroniser
		logic rc_s2;
		logic rc_s3; // edge history, reads second stage only
		logic strap_s1; // strap synchroniser
		logic strap_s2;
	} sadc_top_s;
	sadc_top_s st;
	sadc_top_s next_st;

	sadc_eng_if eng (); // bundle to divider and engine
	logic start_req; // accepted start write
	logic wr_ctrl0; // write to the control register
	logic [4:0] dig_cnt; // inputs turned digital
	logic [12:0] ana_map; // one per input, high = analog
	logic [7:0] rd_mux; // value of the addressed register

	// ==========================================================
	// engine and clock divider
	sadc_tick sadc_tick_inst (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.eng(eng)
	);

	sadc_sar sadc_sar_inst (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.eng(eng)
	);

	// conversion clock only runs while acquiring or converting
	assign eng.run = (st.state == sadc_pkg::ST_ACQ) || (st.state == sadc_pkg::ST_CONV);
	assign eng.clk_sel = st.cs;
	assign eng.rc_edge = st.rc_s2 && !st.rc_s3;
	assign eng.start = st.start;
	assign eng.abort = st.abort;
	assign eng.comp = st.comp_s2;

	// ==========================================================
	// pin map: each code above two turns one more input digital, top first
	assign dig_cnt = (st.pcfg <= sadc_pkg::PCFG_ANALOG_MAX) ? 5'h00 :
		{1'b0, st.pcfg - sadc_pkg::PCFG_ANALOG_MAX};
	for (genvar i = 0; i < 13; i++) begin : g_pin
		assign ana_map[i] = (5'(i) + dig_cnt) < sadc_pkg::NUM_CH;
	end

	// ==========================================================
	// bus decode; start needs an enabled, idle converter
	assign wr_ctrl0 = reg_wr && (reg_addr == sadc_pkg::OFS_CTRL0);
	assign start_req = wr_ctrl0 && reg_wdata[sadc_pkg::GO_BIT] && reg_wdata[sadc_pkg::EN_BIT] &&
		st.en && (st.state == sadc_pkg::ST_IDLE);

	// read view; unimplemented bits and unmapped offsets read zero
	always_comb begin
		case (reg_addr)
			sadc_pkg::OFS_CTRL0: begin
				rd_mux = {2'h0, st.chan, st.en && (st.state != sadc_pkg::ST_IDLE),
					st.en};
			end
			sadc_pkg::OFS_CFG1: begin
				rd_mux = {2'h0, st.nref, st.pref, st.pcfg};
			end
			sadc_pkg::OFS_CFG2: begin
				rd_mux = {st.justify, 1'b0, st.acq, st.cs};
			end
			sadc_pkg::OFS_RES_LO: begin
				rd_mux = st.res_lo;
			end
			sadc_pkg::OFS_RES_HI: begin
				rd_mux = st.res_hi;
			end
			sadc_pkg::OFS_FLAG: begin
				rd_mux = {7'h00, st.flag};
			end
			default: begin
				rd_mux = 8'h00;
			end
		endcase
	end

	// ==========================================================
	// next state
	always_comb begin
		next_st = st;
		next_st.start = 1'b0;
		next_st.abort = 1'b0;
		// synchronisers: first stages feed only second stages
		next_st.comp_s1 = comp_in;
		next_st.comp_s2 = st.comp_s1;
		next_st.rc_s1 = rc_osc_tick;
		next_st.rc_s2 = st.rc_s1;
		next_st.rc_s3 = st.rc_s2;
		next_st.strap_s1 = port_analog_default_option;
		next_st.strap_s2 = st.strap_s1;
		next_st.pin_analog = ana_map;
		// read data stands only in the cycle after the strobe
		next_st.rdata = reg_rd ? rd_mux : 8'h00;

		// register writes
		if (wr_ctrl0) begin
			next_st.chan = reg_wdata[sadc_pkg::CH_LSB +: 4];
			next_st.en = reg_wdata[sadc_pkg::EN_BIT];
		end
		if (reg_wr && (reg_addr == sadc_pkg::OFS_CFG1)) begin
			next_st.nref = reg_wdata[sadc_pkg::NREF_BIT];
			next_st.pref = reg_wdata[sadc_pkg::PREF_BIT];
			next_st.pcfg = reg_wdata[sadc_pkg::PCFG_LSB +: 4];
		end
		if (reg_wr && (reg_addr == sadc_pkg::OFS_CFG2)) begin
			// changing timing mid-conversion is legal but gives a meaningless result
			next_st.justify = reg_wdata[sadc_pkg::JUST_BIT];
			next_st.acq = reg_wdata[sadc_pkg::ACQ_LSB +: 3];
			next_st.cs = reg_wdata[sadc_pkg::CS_LSB +: 3];
		end
		// write one clears the flag; a completion below still wins
		if (reg_wr && (reg_addr == sadc_pkg::OFS_FLAG) && reg_wdata[sadc_pkg::FLAG_BIT]) begin
			next_st.flag = 1'b0;
		end

		// sequencer
		case (st.state)
			sadc_pkg::ST_IDLE: begin
				if (start_req) begin
					if (sadc_pkg::is_rc(st.cs)) begin
						// let the sleep instruction run before the clock starts
						next_st.state = sadc_pkg::ST_DELAY;
						next_st.cnt = 5'(sadc_pkg::INSTR_CYCLES - 1);
					end else if (st.acq != 3'h0) begin
						next_st.state = sadc_pkg::ST_ACQ;
						next_st.cnt = sadc_pkg::acq_tads(st.acq) - 5'h01;
					end else begin
						next_st.state = sadc_pkg::ST_CONV;
						next_st.start = 1'b1;
					end
				end
			end
			sadc_pkg::ST_DELAY: begin
				if (st.cnt != 5'h00) begin
					next_st.cnt = st.cnt - 5'h01;
				end else if (st.acq != 3'h0) begin
					next_st.state = sadc_pkg::ST_ACQ;
					next_st.cnt = sadc_pkg::acq_tads(st.acq) - 5'h01;
				end else begin
					next_st.state = sadc_pkg::ST_CONV;
					next_st.start = 1'b1;
				end
			end
			sadc_pkg::ST_ACQ: begin
				// keep sampling for the programmed number of periods
				if (eng.conversion_clock_period) begin
					if (st.cnt == 5'h00) begin
						next_st.state = sadc_pkg::ST_CONV;
						next_st.start = 1'b1;
					end else begin
						next_st.cnt = st.cnt - 5'h01;
					end
				end
			end
			sadc_pkg::ST_CONV: begin
				if (eng.done) begin
					next_st.state = sadc_pkg::ST_IDLE;
					next_st.flag = 1'b1;
					if (st.justify) begin
						next_st.res_hi = {6'h00, eng.result[9:8]};
						next_st.res_lo = eng.result[7:0];
					end else begin
						next_st.res_hi = eng.result[9:2];
						next_st.res_lo = {eng.result[1:0], 6'h00};
					end
				end
			end
			default: begin
				next_st.state = sadc_pkg::ST_IDLE;
			end
		endcase

		// turning the converter off drops whatever is under way
		if (!next_st.en && (st.state != sadc_pkg::ST_IDLE)) begin
			next_st.state = sadc_pkg::ST_IDLE;
			next_st.abort = 1'b1;
			next_st.start = 1'b0;
			next_st.flag = st.flag;
			next_st.res_hi = st.res_hi;
			next_st.res_lo = st.res_lo;
		end
	end

	// ==========================================================
	// registers; reset is synchronous, results and synchronisers keep running
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			st.state <= sadc_pkg::ST_IDLE;
			st.en <= 1'b0;
			st.chan <= sadc_pkg::CH_RST;
			st.nref <= 1'b0;
			st.pref <= 1'b0;
			// strap has settled through its synchroniser while reset is held
			st.pcfg <= st.strap_s2 ? sadc_pkg::PCFG_RST_ANALOG : sadc_pkg::PCFG_RST_MIXED;
			st.justify <= 1'b0;
			st.acq <= sadc_pkg::FIELD3_RST;
			st.cs <= sadc_pkg::FIELD3_RST;
			st.res_hi <= st.res_hi;
			st.res_lo <= st.res_lo;
			st.flag <= 1'b0;
			st.cnt <= 5'h00;
			st.start <= 1'b0;
			st.abort <= 1'b0;
			st.rdata <= 8'h00;
			st.pin_analog <= ana_map;
			st.comp_s1 <= comp_in;
			st.comp_s2 <= st.comp_s1;
			st.rc_s1 <= rc_osc_tick;
			st.rc_s2 <= st.rc_s1;
			st.rc_s3 <= st.rc_s2;
			st.strap_s1 <= port_analog_default_option;
			st.strap_s2 <= st.strap_s1;
		end else begin
			st <= next_st;
		end
	end

	// ==========================================================
	// outputs
	assign reg_rdata = st.rdata;
	assign channel_select = st.chan;
	assign channel_valid = (st.chan <= sadc_pkg::LAST_CH);
	assign pin_analog = st.pin_analog;
	assign neg_reference_select = st.nref;
	assign pos_reference_select = st.pref;
	// the hold capacitor tracks the input while enabled and not converting
	assign sample_en = st.en && (st.state != sadc_pkg::ST_CONV);
	assign dac_code = eng.trial;
	assign conversion_done_flag = st.flag;

	// ==========================================================
	// checks
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);

	logic [3:0] conv_tads; // periods seen in the current conversion
	always_ff @(posedge core_clk) begin
		if (!rst_n || (st.state != sadc_pkg::ST_CONV)) begin
			conv_tads <= 4'h0;
		end else if (eng.conversion_clock_period) begin
			conv_tads <= conv_tads + 4'h1;
		end
	end

	chan_write_a: assert property (
		wr_ctrl0 |=> channel_select == $past(reg_wdata[5:2])
	) else $error("channel field not taken from write");
	status_read_a: assert property (
		reg_rd && reg_addr == sadc_pkg::OFS_CTRL0 && st.en && st.state == sadc_pkg::ST_CONV
		|=> reg_rdata[1]
	) else $error("status bit low during conversion");
	disable_abort_a: assert property (
		wr_ctrl0 && !reg_wdata[0] |=> st.state == sadc_pkg::ST_IDLE && !sample_en
	) else $error("disable did not stop the converter");
	ref_write_a: assert property (
		reg_wr && reg_addr == sadc_pkg::OFS_CFG1
		|=> neg_reference_select == $past(reg_wdata[5]) && pos_reference_select == $past(reg_wdata[4])
	) else $error("reference selects not taken from write");
	pin_digital_a: assert property (
		st.pcfg == 4'hF |=> pin_analog == 13'h0000
	) else $error("code 15 left an analog input");
	rc_delay_a: assert property (
		start_req && sadc_pkg::is_rc(st.cs) |=> (st.state == sadc_pkg::ST_DELAY) [*4]
		##1 st.state != sadc_pkg::ST_DELAY
	) else $error("rc start delay not one instruction cycle");
	conv_length_a: assert property (
		eng.done && st.state == sadc_pkg::ST_CONV |-> conv_tads == 4'hB
	) else $error("conversion not eleven periods");
	done_flag_a: assert property (
		eng.done && st.state == sadc_pkg::ST_CONV && next_st.en
		|=> conversion_done_flag && st.state == sadc_pkg::ST_IDLE && sample_en
	) else $error("completion not flagged");
	manual_start_a: assert property (
		start_req && st.acq == 3'h0 && !sadc_pkg::is_rc(st.cs) |=> st.state == sadc_pkg::ST_CONV
	) else $error("manual start did not convert at once");
	acq_start_a: assert property (
		start_req && st.acq != 3'h0 && !sadc_pkg::is_rc(st.cs) |=> st.state == sadc_pkg::ST_ACQ
	) else $error("programmed acquisition skipped");
	start_ignore_a: assert property (
		wr_ctrl0 && reg_wdata[1] && !st.en && st.state == sadc_pkg::ST_IDLE
		|=> st.state == sadc_pkg::ST_IDLE
	) else $error("start accepted while disabled");
	reserved_read_a: assert property (
		reg_rd && reg_addr != sadc_pkg::OFS_RES_HI && reg_addr != sadc_pkg::OFS_RES_LO
		|=> reg_rdata[6] == 1'b0
	) else $error("unimplemented bit read nonzero");

	done_cov: cover property (eng.done && st.state == sadc_pkg::ST_CONV && st.acq != 3'h0);
	rc_cov: cover property (st.state == sadc_pkg::ST_DELAY ##1 st.state == sadc_pkg::ST_CONV);
	abort_cov: cover property (st.state == sadc_pkg::ST_CONV ##1 st.abort);
endmodule
`default_nettype wire

/* verification/sadc_hold_model.sv */
// hold capacitor and comparator model at the analog inputs
`timescale 1ns/1ps
`default_nettype none
module sadc_hold_model (
	input wire logic [9:0] level,
	input wire logic sample_en,
	input wire logic [9:0] dac_code,
	output logic comp_in
);
	// ==========
	// charge follows the input only while sampling, then holds it
	logic [9:0] held = 10'h000;
	always @* if (sample_en) held = level;
	// high while the held charge is at or above the trial code
	assign comp_in = (held >= dac_code);
endmodule
`default_nettype wire

/* verification/tb_top.sv */
// self-checking bench of the converter control sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	// ==========
	// stimulus and observed pins
	logic core_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	logic strap = 1'b1, rc_tick = 1'b0, comp_in, chv, nref, pref, smp, flag;
	logic [2:0] reg_addr = 3'h0;
	logic [7:0] reg_wdata = 8'h00, reg_rdata;
	logic [3:0] chs, v;
	logic [12:0] pins;
	logic [9:0] dac, level = 10'h000;
	int n_errors = 0, total_checks = 0, n, lo;
	// acquisition periods and clock divides per code; rc nominal 8
	int at[8] = '{0, 2, 4, 6, 8, 12, 16, 20};
	int dv[8] = '{2, 8, 32, 8, 4, 16, 64, 8};
	always #2.5 core_clk = ~core_clk;
	// slow rc oscillator, 50.6 ns, no phase tie to the core clock
	always #25.3 rc_tick = ~rc_tick;
	sadc_top sadc_top_inst (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.port_analog_default_option(strap), .comp_in(comp_in), .rc_osc_tick(rc_tick),
		.channel_select(chs), .channel_valid(chv), .pin_analog(pins),
		.neg_reference_select(nref), .pos_reference_select(pref), .sample_en(smp),
		.dac_code(dac), .conversion_done_flag(flag));
	sadc_hold_model sadc_hold_model_inst (.level(level), .sample_en(smp), .dac_code(dac),
		.comp_in(comp_in));
	// ==========
	// shared tasks
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] x);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= x;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rdc(input logic [2:0] a, input logic [7:0] e);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		chk(16'(reg_rdata), 16'(e));
	endtask
	// strap settles through a synchroniser, so reset spans 8 edges
	task automatic do_reset(input logic s);
		@(posedge core_clk);
		rst_n <= 1'b0;
		strap <= s;
		repeat (8) @(posedge core_clk);
		rst_n <= 1'b1;
	endtask
	task automatic test_done;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// configure, start, poll, read back, then idle long enough before a restart
	task automatic conv(input logic [7:0] cfg, input logic [9:0] lv, input int l, input int h,
		input logic res, input logic [15:0] exp);
		level <= lv;
		wr(3'h2, cfg);
		wr(3'h0, 8'h03);
		rdc(3'h0, 8'h03);
		n = 2;
		while (flag !== 1'b1 && n < 3000) begin
			@(posedge core_clk);
			#1;
			n++;
		end
		chk(16'(n >= l && n <= h), 16'h0001);
		rdc(3'h0, 8'h01);
		chk(16'(smp), 16'h0001);
		if (res) begin
			rdc(3'h4, exp[15:8]);
			rdc(3'h3, exp[7:0]);
			// the last trial code stays on the dac until the next start
			chk(16'(dac), 16'(lv));
		end
		wr(3'h5, 8'h01);
		repeat (200) @(posedge core_clk);
	endtask
	// ==========
	// scenarios
	// values straight after reset with the strap high, and an unmapped index
	task automatic t_reset_values;
		rdc(3'h0, 8'h00);
		rdc(3'h1, 8'h00);
		rdc(3'h2, 8'h00);
		rdc(3'h7, 8'h00);
	endtask
	// all ones written; unimplemented bits read zero, start from disabled dropped
	task automatic t_reserved_bits;
		wr(3'h0, 8'hFF);
		rdc(3'h0, 8'h3D);
		wr(3'h1, 8'hFF);
		rdc(3'h1, 8'h3F);
		wr(3'h2, 8'hFF);
		rdc(3'h2, 8'hBF);
	endtask
	// every channel and pin code, references alternating
	task automatic t_pins;
		for (int i = 0; i < 16; i++) begin
			v = 4'(i);
			wr(3'h0, {2'h0, v, 2'h0});
			wr(3'h1, {2'h0, v[0], ~v[0], v});
			@(posedge core_clk);
			#1;
			chk(16'(chs), 16'(v));
			chk(16'(chv), 16'(v <= 4'hC));
			chk(16'({nref, pref}), 16'({v[0], ~v[0]}));
			chk(16'(pins), (v <= 4'h2) ? 16'h1FFF : 16'h1FFF >> (v - 4'h2));
		end
	endtask
	// each clock and acquisition code; x11 runs on rc, as sleep needs
	task automatic t_clocks;
		wr(3'h0, 8'h01);
		for (int i = 0; i < 8; i++) begin
			lo = (at[i] + 11) * dv[i];
			conv({2'h2, 3'(i), 3'(i)}, 10'h000, lo, (i % 4 == 3) ? lo + lo / 4 + 30 : lo + 6,
				1'b0, 16'h0000);
		end
		// rc clock with no acquisition: delay runs straight into the conversion
		conv(8'h83, 10'h000, 88, 140, 1'b0, 16'h0000);
		conv(8'h81, 10'h2A5, 88, 94, 1'b1, 16'h02A5);
		conv(8'h39, 10'h15A, 248, 254, 1'b1, 16'h5680);
	endtask
	// start from disabled is dropped, start while busy too; disabling drops the run
	task automatic t_disable;
		wr(3'h2, 8'h06);
		wr(3'h0, 8'h00);
		wr(3'h0, 8'h03);
		rdc(3'h0, 8'h01);
		wr(3'h0, 8'h03);
		repeat (100) @(posedge core_clk);
		wr(3'h0, 8'h07);
		rdc(3'h0, 8'h07);
		wr(3'h0, 8'h00);
		repeat (800) @(posedge core_clk);
		chk(16'(flag), 16'h0000);
		rdc(3'h0, 8'h00);
	endtask
	// reset in mid-conversion with the strap low
	task automatic t_mid_reset;
		wr(3'h0, 8'h01);
		wr(3'h0, 8'h03);
		repeat (100) @(posedge core_clk);
		do_reset(1'b0);
		repeat (800) @(posedge core_clk);
		chk(16'(flag), 16'h0000);
		rdc(3'h0, 8'h00);
		rdc(3'h1, 8'h07);
		rdc(3'h4, 8'h56);
		rdc(3'h3, 8'h80);
	endtask
	initial begin
		do_reset(1'b1);
		t_reset_values();
		t_reserved_bits();
		t_pins();
		t_clocks();
		t_disable();
		t_mid_reset();
		test_done();
	end
	// watchdog well past the expected run of about 8000 cycles
	initial begin
		#100000;
		n_errors++;
		test_done();
	end
endmodule
`default_nettype wire
